// [test/coil_driver_output_control_tb.sv]
// coil_driver_output_control_tb: self-checking bench for the coil driver control block
// assumes the block's commands arrive as decoded pulses; load model stands for coils and boost
`default_nettype none
module coil_driver_output_control_tb;
  import coil_drv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BD = 8;
  localparam int CD = 16;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic chip_select = 1'b0;
  cmd_s cmd = '0;
  logic line_short = 1'b0;
  logic over_i = 1'b0;
  logic over_v = 1'b0;
  logic [LEVEL_W-1:0] battery_level = 12'h300;
  logic [LEVEL_W-1:0] integrator_raw = 12'hFFF;
  wire logic shunt_sense_input, boost_switch_current, boost_output_voltage;
  wire logic [LEVEL_W-1:0] shunt_level;
  pos_lines_s pos;
  ret_lines_s ret;
  logic boost_enable, boost_switch, sample_strobe, carrier_tick;
  logic [4:0] steps [6] = '{5'h00, 5'h03, 5'h04, 5'h0D, 5'h0E, 5'h13};
  logic signed [LEVEL_W:0] reg_difference;
  logic [LEVEL_W-1:0] integrator_cap_pin;
  logic [2:0] mode_state;
  logic [STEP_W-1:0] step_index;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  coil_driver_output_control #(.BOOST_DIV_P(BD), .CARRIER_DIV_P(CD))
    coil_driver_output_control_inst (.clk_sys(clk_sys), .rst(rst), .chip_select(chip_select),
    .cmd(cmd), .line_short(line_short), .boost_switch_current(boost_switch_current),
    .boost_output_voltage(boost_output_voltage), .shunt_sense_input(shunt_sense_input),
    .shunt_level(shunt_level), .battery_level(battery_level), .integrator_raw(integrator_raw),
    .coil_positive_line(pos), .coil_return_line(ret), .boost_enable(boost_enable),
    .boost_switch(boost_switch), .carrier_tick(carrier_tick), .sample_strobe(sample_strobe),
    .reg_difference(reg_difference), .integrator_cap_pin(integrator_cap_pin),
    .mode_state(mode_state), .step_index(step_index));
  coil_load_model #(.CARRIER_DIV_P(CD)) coil_load_model_inst (.clk_sys(clk_sys),
    .coil_positive_line(pos), .over_i(over_i), .over_v(over_v),
    .shunt_sense_input(shunt_sense_input), .shunt_level(shunt_level),
    .boost_switch_current(boost_switch_current), .boost_output_voltage(boost_output_voltage));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // pulse lasts one cycle; one more edge lets the integrator level follow the new mode
  task automatic pulse(input cmd_s c);
    @(negedge clk_sys) cmd = c;
    @(negedge clk_sys) cmd = '0;
    @(negedge clk_sys);
  endtask
  task automatic count_high(output int n);
    n = 0;
    repeat (BD) @(negedge clk_sys) n += int'(boost_switch === 1'b1);
  endtask
  task automatic t_wake();
    int n;
    chip_select = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("mode", 16'h1, 16'(mode_state));
    n = 0;
    repeat (CD) @(negedge clk_sys) n += int'(carrier_tick === 1'b1);
    chk("carrier ticks", 16'h1, 16'(n));
    pulse('{set_coil: 1'b1, coil_sel: 3'h2, default: '0});
    chk("pos mid", 16'h04, 16'(pos.mid_park));
    chk("pos high", 16'h3B, 16'(pos.high_level));
    chk("ret low", 16'h04, 16'(ret.sink_low));
    chk("ret pullup", 16'h3B, 16'(ret.pullup_on));
    chk("boost idle", 16'h0, 16'(boost_enable));
    chk("integ idle", 16'(battery_level), 16'(integrator_cap_pin));
  endtask
  task automatic t_step(input logic [4:0] idx);
    int n;
    int e;
    pulse('{set_step: 1'b1, step_sel: idx, default: '0});
    chk("step", 16'(idx), 16'(step_index));
    pulse('{start_tx: 1'b1, default: '0});
    @(posedge shunt_sense_input);
    n = 0;
    while (sample_strobe !== 1'b1 && n < 40) @(negedge clk_sys) n++;
    chk("strobe delay", 16'h1, 16'(n >= CD / 4 - 1 && n <= CD / 4 + 2));
    repeat (2) @(negedge clk_sys);
    e = (int'(idx) + 1) * STEP_MA - 200;
    chk("difference", 16'(e), 16'(reg_difference));
    pulse('{end_tx: 1'b1, default: '0});
  endtask
  task automatic t_boost();
    int n;
    pulse('{start_tx: 1'b1, default: '0});
    chk("mode op", 16'h2, 16'(mode_state));
    chk("sine", 16'h04, 16'(pos.sine_active));
    chk("boost op", 16'h1, 16'(boost_enable));
    chk("integ max", 16'(LEVEL_MAX), 16'(integrator_cap_pin));
    count_high(n);
    chk("boost duty", 16'(BD / 2), 16'(n));
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_sys) {over_i, over_v} = k ? 2'b01 : 2'b10;
      count_high(n);
      chk("boost stop", 16'h0, 16'(n));
      {over_i, over_v} = 2'b00;
    end
    pulse('{end_tx: 1'b1, default: '0});
    chk("boost off", 16'h0, 16'(boost_enable));
  endtask
  task automatic t_fault();
    @(negedge clk_sys) line_short = 1'b1;
    repeat (2) @(negedge clk_sys) line_short = 1'b0;
    chk("shutdown", 16'h3, 16'(mode_state));
    chk("pos hiz", 16'h0, 16'(pos.drive_en));
    chk("ret hiz", 16'h0, 16'(ret.drive_en));
    pulse('{start_tx: 1'b1, default: '0});
    chk("tx ignored", 16'h3, 16'(mode_state));
    pulse('{fault_reset: 1'b1, default: '0});
    chk("fault exit", 16'h1, 16'(mode_state));
    pulse('{to_diag: 1'b1, default: '0});
    chk("diag", 16'h4, 16'(mode_state));
    chk("diag hiz", 16'h0, 16'(pos.drive_en));
    chk("diag boost", 16'h0, 16'(boost_enable));
    pulse('{leave_diag: 1'b1, default: '0});
    chk("diag exit", 16'h1, 16'(mode_state));
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // whole run needs well under 3000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    chk("reset mode", 16'h0, 16'(mode_state));
    chk("reset lines", 16'h0, 16'(pos.drive_en));
    chk("reset boost", 16'h0, 16'(boost_enable));
    t_wake();
    foreach (steps[i]) begin
      t_step(steps[i]);
    end
    pulse('{set_step: 1'b1, step_sel: 5'h14, default: '0});
    chk("step refused", 16'h13, 16'(step_index));
    t_boost();
    t_fault();
    final_report();
  end
endmodule
`default_nettype wire

// [test/coil_load_model.sv]
// coil_load_model: coil, shunt sense and boost parts at the block's far side
// assumes it shares clk_sys with the block and changes its outputs at the falling edge
`default_nettype none
module coil_load_model
  import coil_drv_pkg::*;
#(
  parameter int CARRIER_DIV_P = 16,
  parameter logic [LEVEL_W-1:0] PEAK = 12'h0C8
) (
  input wire logic clk_sys,
  input wire coil_drv_pkg::pos_lines_s coil_positive_line,
  input wire logic over_i,
  input wire logic over_v,
  output logic shunt_sense_input,
  output logic [LEVEL_W-1:0] shunt_level,
  output logic boost_switch_current,
  output logic boost_output_voltage
);
  int phase = 0;
  initial begin
    shunt_sense_input = 1'b0;
    shunt_level = PEAK;
  end
  // over-limit flags follow the bench's requests directly, so no edge race with the counter
  assign boost_switch_current = over_i;
  assign boost_output_voltage = over_v;
  // current flows only while a line carries the sine, so no crossings otherwise
  always @(negedge clk_sys) begin
    if (|coil_positive_line.sine_active) begin
      phase = (phase + 1) % CARRIER_DIV_P;
    end else begin
      phase = 0;
    end
    shunt_sense_input <= (phase >= CARRIER_DIV_P / 2);
  end
endmodule
`default_nettype wire

// [verilog/coil_driver_output_control.sv]
// coil_driver_output_control: mode sequencing, coil line states, boost control,
// peak sample timing and current reference for the LF coil driver.
// assumes commands are already decoded from the serial port into one-cycle pulses,
// and comparator flags and sampled levels arrive synchronous to clk_sys.
`default_nettype none
module coil_driver_output_control
  import coil_drv_pkg::*;
#(
  parameter int BOOST_DIV_P = BOOST_DIV,
  parameter int CARRIER_DIV_P = CARRIER_DIV
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_select,
  input wire coil_drv_pkg::cmd_s cmd,
  input wire logic line_short,
  input wire logic boost_switch_current,
  input wire logic boost_output_voltage,
  input wire logic shunt_sense_input,
  input wire logic [LEVEL_W-1:0] shunt_level,
  input wire logic [LEVEL_W-1:0] battery_level,
  input wire logic [LEVEL_W-1:0] integrator_raw,
  output coil_drv_pkg::pos_lines_s coil_positive_line,
  output coil_drv_pkg::ret_lines_s coil_return_line,
  output logic boost_enable,
  output logic boost_switch,
  output logic carrier_tick,
  output logic sample_strobe,
  output logic signed [LEVEL_W:0] reg_difference,
  output logic [LEVEL_W-1:0] integrator_cap_pin,
  output logic [2:0] mode_state,
  output logic [STEP_W-1:0] step_index
);
  import coil_drv_pkg::*;

  localparam int BW = $clog2(BOOST_DIV_P);
  localparam int CW = $clog2(CARRIER_DIV_P);
  localparam logic [CW-1:0] QUARTER = CW'(CARRIER_DIV_P / 4);

  mode_e mode_reg, mode_next;
  logic [2:0] coil_reg;
  logic [STEP_W-1:0] step_reg;
  logic [BW-1:0] bdiv_reg;
  logic [CW-1:0] cdiv_reg;
  logic [CW-1:0] qcnt_reg;
  logic qrun_reg;
  logic zc_prev_reg;
  logic boost_trip_reg;
  logic boost_sw_reg;
  logic [LEVEL_W-1:0] peak_reg;
  logic sample_reg;
  logic [LEVEL_W-1:0] integ_reg;
  logic signed [LEVEL_W:0] diff_reg;

  wire operate = (mode_reg == MODE_OPERATE);
  wire idle = (mode_reg == MODE_IDLE);
  wire lines_on = operate || idle;
  wire [NUM_COILS-1:0] sel_onehot = NUM_COILS'(1) << coil_reg;
  wire zero_cross = shunt_sense_input && !zc_prev_reg;
  wire over_limit = boost_switch_current || boost_output_voltage;
  wire bdiv_wrap = (bdiv_reg == BW'(BOOST_DIV_P - 1));
  wire cdiv_wrap = (cdiv_reg == CW'(CARRIER_DIV_P - 1));
  wire q_done = qrun_reg && (qcnt_reg == QUARTER - CW'(1));
  // reference in mA: (index+1)*50
  wire [LEVEL_W-1:0] step_ref = LEVEL_W'((32'(step_reg) + 32'd1) * STEP_MA / MA_PER_LSB);

  // mode sequencing
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_POWER_DOWN: if (chip_select) mode_next = MODE_IDLE;
      MODE_IDLE: begin
        if (line_short) mode_next = MODE_SHUTDOWN;
        else if (cmd.to_diag) mode_next = MODE_DIAG;
        else if (cmd.start_tx) mode_next = MODE_OPERATE;
      end
      MODE_OPERATE: begin
        if (line_short) mode_next = MODE_SHUTDOWN;
        else if (cmd.end_tx) mode_next = MODE_IDLE;
      end
      // transmit commands ignored until fault reset
      MODE_SHUTDOWN: if (cmd.fault_reset) mode_next = MODE_IDLE;
      MODE_DIAG: if (cmd.leave_diag || cmd.fault_reset) mode_next = MODE_IDLE;
      default: mode_next = MODE_POWER_DOWN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) mode_reg <= MODE_POWER_DOWN;
    else mode_reg <= mode_next;
  end

  // selection registers; out-of-range steps are refused
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      coil_reg <= COIL_RESET;
      step_reg <= STEP_RESET;
    end else begin
      if (cmd.set_coil && !operate && cmd.coil_sel < 3'(NUM_COILS)) coil_reg <= cmd.coil_sel;
      if (cmd.set_step && cmd.step_sel <= STEP_LAST) step_reg <= cmd.step_sel;
    end
  end

  // line states per coil
  genvar i;
  generate
    for (i = 0; i < NUM_COILS; i++) begin : g_line
      wire sel = sel_onehot[i];
      assign coil_positive_line.sine_active[i] = operate && sel;
      assign coil_positive_line.mid_park[i] = idle && sel;
      assign coil_positive_line.high_level[i] = lines_on && !sel;
      assign coil_positive_line.drive_en[i] = lines_on;
      assign coil_return_line.sink_low[i] = lines_on && sel;
      assign coil_return_line.pullup_on[i] = lines_on && !sel;
      assign coil_return_line.drive_en[i] = lines_on && sel;
    end
  endgenerate

  // boost switching divider; shares clk_sys with the carrier timing
  always_ff @(posedge clk_sys) begin
    if (rst || !operate) bdiv_reg <= '0;
    else bdiv_reg <= bdiv_wrap ? '0 : bdiv_reg + BW'(1);
  end

  // trip holds off switching until the next switching period starts clean
  always_ff @(posedge clk_sys) begin
    if (rst || !operate) begin
      boost_trip_reg <= 1'b0;
      boost_sw_reg <= 1'b0;
    end else begin
      if (over_limit) boost_trip_reg <= 1'b1;
      else if (bdiv_wrap) boost_trip_reg <= 1'b0;
      boost_sw_reg <= !over_limit && !boost_trip_reg &&
        (bdiv_reg < BW'(BOOST_DIV_P / 2));
    end
  end

  assign boost_enable = operate;
  assign boost_switch = boost_sw_reg && !over_limit;

  // carrier timebase
  always_ff @(posedge clk_sys) begin
    if (rst) cdiv_reg <= '0;
    else cdiv_reg <= cdiv_wrap ? '0 : cdiv_reg + CW'(1);
  end
  assign carrier_tick = cdiv_wrap;

  // peak sampling a quarter period after zero crossing
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      zc_prev_reg <= 1'b0;
      qrun_reg <= 1'b0;
      qcnt_reg <= '0;
      sample_reg <= 1'b0;
      peak_reg <= '0;
    end else begin
      zc_prev_reg <= shunt_sense_input;
      sample_reg <= q_done;
      if (zero_cross) begin
        qrun_reg <= 1'b1;
        qcnt_reg <= '0;
      end else if (q_done) begin
        qrun_reg <= 1'b0;
        peak_reg <= shunt_level;
      end else if (qrun_reg) qcnt_reg <= qcnt_reg + CW'(1);
    end
  end
  assign sample_strobe = sample_reg;

  // regulation difference and integrator level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diff_reg <= '0;
      integ_reg <= '0;
    end else begin
      diff_reg <= $signed({1'b0, step_ref}) - $signed({1'b0, peak_reg});
      if (idle) integ_reg <= battery_level;
      else if (operate) integ_reg <= (integrator_raw > LEVEL_MAX) ? LEVEL_MAX : integrator_raw;
      else integ_reg <= '0;
    end
  end

  assign reg_difference = diff_reg;
  assign integrator_cap_pin = integ_reg;
  assign mode_state = 3'(mode_reg);
  assign step_index = step_reg;

  a_boost_only_tx: assert property (@(posedge clk_sys) disable iff (rst)
    boost_enable |-> mode_reg == MODE_OPERATE) else $error("boost on outside transmission");
  a_boost_stop: assert property (@(posedge clk_sys) disable iff (rst)
    over_limit |-> !boost_switch) else $error("boost switching while over limit");
  a_trip_hold: assert property (@(posedge clk_sys) disable iff (rst)
    operate && over_limit && !bdiv_wrap ##1 operate |-> !boost_sw_reg)
    else $error("boost not held after trip");
  sequence s_cross;
    shunt_sense_input && !zc_prev_reg;
  endsequence
  a_quarter_sample: assert property (@(posedge clk_sys) disable iff (rst)
    s_cross ##1 (!(shunt_sense_input && !zc_prev_reg))[*2] |-> !sample_strobe)
    else $error("sample too early");
  a_idle_park: assert property (@(posedge clk_sys) disable iff (rst)
    idle |-> coil_positive_line.mid_park == sel_onehot && coil_return_line.sink_low == sel_onehot)
    else $error("idle line state wrong");
  a_hiz_other: assert property (@(posedge clk_sys) disable iff (rst)
    !lines_on |-> coil_positive_line.drive_en == '0 && coil_return_line.pullup_on == '0)
    else $error("lines driven outside idle or operate");
  a_pullup_unsel: assert property (@(posedge clk_sys) disable iff (rst)
    lines_on |-> coil_return_line.pullup_on == ~sel_onehot)
    else $error("unselected return not pulled up");
  a_wake_idle: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == MODE_POWER_DOWN && chip_select |=> mode_reg == MODE_IDLE)
    else $error("chip select did not wake");
  a_short_stop: assert property (@(posedge clk_sys) disable iff (rst)
    lines_on && line_short |=> mode_reg == MODE_SHUTDOWN) else $error("short not handled");
  a_shut_hold: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == MODE_SHUTDOWN && !cmd.fault_reset |=> mode_reg == MODE_SHUTDOWN)
    else $error("shutdown left without fault reset");
  a_integ_idle: assert property (@(posedge clk_sys) disable iff (rst)
    idle |=> integ_reg == $past(battery_level) || !$past(idle)) else $error("idle level wrong");
  a_integ_clamp: assert property (@(posedge clk_sys) disable iff (rst)
    $past(operate) |-> integ_reg <= LEVEL_MAX) else $error("integrator above max");
  a_step_range: assert property (@(posedge clk_sys) disable iff (rst)
    step_reg <= STEP_LAST) else $error("step out of range");
  a_sine_sel: assert property (@(posedge clk_sys) disable iff (rst)
    operate |-> coil_positive_line.sine_active == sel_onehot)
    else $error("sine not on selected line");
  a_high_others: assert property (@(posedge clk_sys) disable iff (rst)
    lines_on |-> coil_positive_line.high_level == ~sel_onehot)
    else $error("unselected positive line not high");
  a_ret_sink: assert property (@(posedge clk_sys) disable iff (rst)
    lines_on |-> coil_return_line.sink_low == sel_onehot && coil_return_line.drive_en == sel_onehot)
    else $error("selected return not held low");
  a_ret_hiz: assert property (@(posedge clk_sys) disable iff (rst)
    !lines_on |-> coil_return_line.drive_en == '0)
    else $error("return driven outside idle or operate");
  a_diag_hiz: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == MODE_DIAG |-> coil_positive_line.drive_en == '0 && !boost_enable)
    else $error("stage active in diagnosis");
  a_boost_idle_off: assert property (@(posedge clk_sys) disable iff (rst)
    idle |-> !boost_enable) else $error("boost on in idle");
  a_switch_only_tx: assert property (@(posedge clk_sys) disable iff (rst)
    !operate |-> !boost_switch) else $error("boost switching outside transmission");
  // a stuck divider would stretch the switching period without any other symptom
  a_bdiv_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    bdiv_wrap |=> bdiv_reg == '0) else $error("boost divider did not wrap");
  a_carrier_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    carrier_tick |=> !carrier_tick) else $error("carrier tick longer than one cycle");
  a_strobe_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    sample_strobe |=> !sample_strobe) else $error("sample strobe longer than one cycle");
  sequence s_quarter;
    q_done && !zero_cross;
  endsequence
  a_peak_capture: assert property (@(posedge clk_sys) disable iff (rst)
    s_quarter |=> sample_strobe && peak_reg == $past(shunt_level))
    else $error("peak not captured at quarter period");
  a_diff_zero: assert property (@(posedge clk_sys) disable iff (rst)
    step_ref == peak_reg |=> diff_reg == '0) else $error("difference not zero on match");
  a_ref_range: assert property (@(posedge clk_sys) disable iff (rst)
    step_ref >= LEVEL_W'(STEP_MA) && step_ref <= LEVEL_W'(NUM_STEPS * STEP_MA))
    else $error("reference outside step range");
  a_step_take: assert property (@(posedge clk_sys) disable iff (rst)
    cmd.set_step && cmd.step_sel <= STEP_LAST |=> step_reg == $past(cmd.step_sel))
    else $error("valid step not taken");
  a_step_keep: assert property (@(posedge clk_sys) disable iff (rst)
    cmd.set_step && cmd.step_sel > STEP_LAST |=> $stable(step_reg))
    else $error("invalid step taken");
  // integrator parked at zero keeps a later idle entry starting from a known level
  a_integ_off: assert property (@(posedge clk_sys) disable iff (rst)
    $past(!lines_on) |-> integ_reg == '0) else $error("integrator not parked");
  a_pd_wait: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == MODE_POWER_DOWN && !chip_select |=> mode_reg == MODE_POWER_DOWN)
    else $error("power-down left without chip select");
  a_shut_no_boost: assert property (@(posedge clk_sys) disable iff (rst)
    mode_reg == MODE_SHUTDOWN |-> !boost_enable && coil_positive_line.drive_en == '0)
    else $error("stage active in shutdown");
endmodule
`default_nettype wire

// [verilog/coil_drv_pkg.sv]
// coil_drv_pkg: constants and carrier types for the coil driver control block
// assumes a single 50 MHz system clock and digital stand-ins for the analog levels
`default_nettype none
package coil_drv_pkg;
  localparam int NUM_COILS = 6;
  localparam int NUM_STEPS = 20;
  localparam int STEP_W = 5;
  localparam int LEVEL_W = 12;
  localparam int STEP_MA = 50;
  localparam int CLK_HZ = 50_000_000;
  localparam int BOOST_HZ = 125_000;
  localparam int BOOST_DIV = CLK_HZ / BOOST_HZ;
  localparam int CARRIER_HZ = 125_000;
  localparam int CARRIER_DIV = CLK_HZ / CARRIER_HZ;
  localparam int QUARTER_DIV = CARRIER_DIV / 4;
  localparam int MA_PER_LSB = 1;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 12'hFA0;
  localparam logic [LEVEL_W-1:0] BAT_LEVEL_DEF = 12'h400;
  localparam logic [STEP_W-1:0] STEP_RESET = 5'h00;
  localparam logic [STEP_W-1:0] STEP_LAST = 5'h13;
  localparam logic [2:0] COIL_RESET = 3'h0;

  typedef enum {
    MODE_POWER_DOWN, MODE_IDLE, MODE_OPERATE, MODE_SHUTDOWN, MODE_DIAG
  } mode_e;

  // per-line drive: drive_en high means the pin stage is driving
  typedef struct packed {
    logic [NUM_COILS-1:0] sine_active;
    logic [NUM_COILS-1:0] mid_park;
    logic [NUM_COILS-1:0] high_level;
    logic [NUM_COILS-1:0] drive_en;
  } pos_lines_s;

  typedef struct packed {
    logic [NUM_COILS-1:0] sink_low;
    logic [NUM_COILS-1:0] pullup_on;
    logic [NUM_COILS-1:0] drive_en;
  } ret_lines_s;

  typedef struct packed {
    logic start_tx;
    logic end_tx;
    logic to_diag;
    logic leave_diag;
    logic fault_reset;
    logic set_coil;
    logic [2:0] coil_sel;
    logic set_step;
    logic [STEP_W-1:0] step_sel;
  } cmd_s;
endpackage
`default_nettype wire
